// file: tlf_pkg.sv
// Purpose: Shared constants and types for the transmit line front end.
// Assumes: clk is the free-running 20 MHz master clock.
// Notes: APB register map, field positions, stall and bit-period counts.
package tlf_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	// Bit periods of the two line rates, in ns
	localparam int T1_BIT_NS = 648;
	localparam int E1_BIT_NS = 488;
	// Cycles per all-ones bit, rounded down
	localparam logic [3:0] AIS_DIV_T1 = 4'(T1_BIT_NS / CLK_PERIOD_NS);
	localparam logic [3:0] AIS_DIV_E1 = 4'(E1_BIT_NS / CLK_PERIOD_NS);
	// Stall thresholds in master-clock cycles
	localparam logic [4:0] STALL_HIGH_CYC = 5'h10;
	localparam logic [6:0] STALL_LOW_CYC = 7'h40;

	// ----------------------------------------
	// APB register map
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	// Control fields
	localparam int CTRL_SINGLE_RAIL = 0;
	localparam int CTRL_AMI = 1;
	localparam int CTRL_E1 = 2;
	localparam int CTRL_CLK_INV = 3;
	localparam int CTRL_OUT_DIS = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	// Status fields
	localparam int STAT_ALL_ONES = 0;
	localparam int STAT_PWR_DOWN = 1;
	localparam int STAT_FIFO_FULL = 2;
	localparam int STAT_OVERFLOW = 3;

	// ----------------------------------------
	// Buffer and coder
	// ----------------------------------------
	localparam int FIFO_W = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int WIN_LEN = 8;

	typedef enum logic [1:0] {MK_ZERO, MK_ONE, MK_VIOL, MK_BAL} tlf_mark_t;
	typedef enum logic [1:0] {LS_NORMAL, LS_ALL_ONES, LS_POWER_DOWN} tlf_line_state_t;

endpackage

// file: tlf_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are slow levels relative to clk.
// Notes: Only the second stage is visible outside.
module tlf_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Levels
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule // tlf_sync2

// file: tlf_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock.
// Notes: Full and empty come from an occupancy count.
module tlf_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic push;
	logic pop;

	// Handshakes
	assign in_ready = (count_r != (PW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_r];

	// Storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // tlf_fifo

// file: tlf_tx_line_front_end.sv
// Purpose: One channel of the digital transmit line front end.
// Assumes: clk is the free-running master clock; pins arrive asynchronously.
// Notes: Line outputs are pulse rails with enables; the pad resolves high impedance.
module tlf_tx_line_front_end (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tlf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Framer side pins
	input wire logic tx_channel_clock,
	input wire logic tx_positive_rail,
	input wire logic tx_negative_rail,
	input wire logic output_enable_pin,
	// Line side
	output logic line_out_tip,
	output logic line_out_ring,
	output logic line_out_tip_oe,
	output logic line_out_ring_oe
);
	import tlf_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [3:0] pin_s;
	logic clk_s, pos_s, neg_s, oe_s;
	logic clk_d_r;
	logic clk_rise, clk_fall, toggled, sample_edge, send_edge;
	logic ctrl_single_r, ctrl_ami_r, ctrl_e1_r, ctrl_inv_r, ctrl_odis_r;
	logic ovf_r;
	logic apb_access, wr_en, rd_load;
	logic [4:0] hi_cnt_r;
	logic [6:0] lo_cnt_r;
	tlf_line_state_t st_r;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;
	tlf_mark_t win_r [0:WIN_LEN-1];
	tlf_mark_t win_nxt [0:WIN_LEN-1];
	logic zpar_r, zpar_nxt;
	logic last_pol_r;
	logic [3:0] ais_cnt_r;
	logic ais_tick;
	logic new_one;

	// Decode one register address
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		addr_is = (a == t);
	endfunction

	// Newest n window slots all plain zero
	function automatic logic zeros_in(input tlf_mark_t w [0:WIN_LEN-1], input int n);
		zeros_in = 1'b1;
		for (int i = 0; i < WIN_LEN; i++) begin
			if (i < n && w[i] != MK_ZERO) begin
				zeros_in = 1'b0;
			end
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisation and edge detect
	// ----------------------------------------
	tlf_sync2 #(.WIDTH(4)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d_in({tx_channel_clock, tx_positive_rail, tx_negative_rail, output_enable_pin}),
		.q_out(pin_s)
	);
	assign {clk_s, pos_s, neg_s, oe_s} = pin_s;

	// Previous synced clock, for edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_d_r <= 1'b0;
		end else begin
			clk_d_r <= clk_s;
		end
	end
	assign clk_rise = clk_s & ~clk_d_r;
	assign clk_fall = ~clk_s & clk_d_r;
	assign toggled = clk_s ^ clk_d_r;
	// Sample on one edge, launch on the other
	assign sample_edge = ctrl_inv_r ? clk_rise : clk_fall;
	assign send_edge = ctrl_inv_r ? clk_fall : clk_rise;

	// ----------------------------------------
	// APB slave, one wait state on every access
	// ----------------------------------------
	assign apb_access = psel & penable;
	assign wr_en = apb_access & pready & pwrite;
	assign rd_load = apb_access & ~pready & ~pwrite;

	// Ready and error, both registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_access & ~pready;
			pslverr <= apb_access & ~pready & ~addr_is(paddr, ADDR_CTRL)
				& ~addr_is(paddr, ADDR_STATUS);
		end
	end

	// Read data captured before ready; unmapped reads zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= 32'h0000_0000;
		end else if (rd_load) begin
			prdata <= 32'h0000_0000;
			if (addr_is(paddr, ADDR_CTRL)) begin
				prdata[CTRL_SINGLE_RAIL] <= ctrl_single_r;
				prdata[CTRL_AMI] <= ctrl_ami_r;
				prdata[CTRL_E1] <= ctrl_e1_r;
				prdata[CTRL_CLK_INV] <= ctrl_inv_r;
				prdata[CTRL_OUT_DIS] <= ctrl_odis_r;
			end else if (addr_is(paddr, ADDR_STATUS)) begin
				prdata[STAT_ALL_ONES] <= (st_r == LS_ALL_ONES);
				prdata[STAT_PWR_DOWN] <= (st_r == LS_POWER_DOWN);
				prdata[STAT_FIFO_FULL] <= ~fifo_in_ready;
				prdata[STAT_OVERFLOW] <= ovf_r;
			end
		end
	end

	// Control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{ctrl_odis_r, ctrl_inv_r, ctrl_e1_r, ctrl_ami_r, ctrl_single_r} <= CTRL_RESET;
		end else if (wr_en && addr_is(paddr, ADDR_CTRL)) begin
			ctrl_single_r <= pwdata[CTRL_SINGLE_RAIL];
			ctrl_e1_r <= pwdata[CTRL_E1];
			ctrl_inv_r <= pwdata[CTRL_CLK_INV];
			ctrl_odis_r <= pwdata[CTRL_OUT_DIS];
			// Coding choice only taken with single-rail selected
			if (pwdata[CTRL_SINGLE_RAIL]) begin
				ctrl_ami_r <= pwdata[CTRL_AMI];
			end
		end
	end

	// Sticky overflow; a new drop beats a write-one clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ovf_r <= 1'b0;
		end else if (fifo_in_valid && !fifo_in_ready) begin
			ovf_r <= 1'b1;
		end else if (wr_en && addr_is(paddr, ADDR_STATUS) && pwdata[STAT_OVERFLOW]) begin
			ovf_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Stall detection on the master clock
	// ----------------------------------------
	// Run lengths saturate at their thresholds
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt_r <= 5'h00;
			lo_cnt_r <= 7'h00;
		end else if (toggled) begin
			hi_cnt_r <= 5'h00;
			lo_cnt_r <= 7'h00;
		end else if (clk_s) begin
			if (hi_cnt_r != STALL_HIGH_CYC) begin
				hi_cnt_r <= hi_cnt_r + 5'h01;
			end
		end else if (lo_cnt_r != STALL_LOW_CYC) begin
			lo_cnt_r <= lo_cnt_r + 7'h01;
		end
	end

	// Line state; any transition restores normal service
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= LS_NORMAL;
		end else begin
			case (st_r)
				LS_NORMAL: begin
					if (hi_cnt_r == STALL_HIGH_CYC) begin
						st_r <= LS_ALL_ONES;
					end else if (lo_cnt_r == STALL_LOW_CYC) begin
						st_r <= LS_POWER_DOWN;
					end
				end
				LS_ALL_ONES: begin
					if (toggled) begin
						st_r <= LS_NORMAL;
					end
				end
				LS_POWER_DOWN: begin
					if (toggled) begin
						st_r <= LS_NORMAL;
					end
				end
				default: begin
					st_r <= LS_NORMAL;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Sample buffer
	// ----------------------------------------
	// Push on every sample edge; a full buffer drops and flags
	assign fifo_in_valid = sample_edge;
	assign fifo_in_data = {pos_s, neg_s};
	// Drains only while the line carries data, so a halted line fills it
	assign fifo_out_ready = send_edge & (st_r == LS_NORMAL);

	tlf_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------
	// Zero-substitution coder
	// ----------------------------------------
	// Underrun shifts in a space rather than stalling the line
	assign new_one = fifo_out_valid & fifo_out_data[1];

	// Window shift; slot 0 newest, last slot goes to the line
	always_comb begin
		win_nxt[0] = new_one ? MK_ONE : MK_ZERO;
		for (int i = 1; i < WIN_LEN; i++) begin
			win_nxt[i] = win_r[i-1];
		end
		zpar_nxt = zpar_r ^ new_one;
		if (ctrl_single_r && !ctrl_ami_r) begin
			if (ctrl_e1_r && zeros_in(win_nxt, 4)) begin
				// HDB3: balance pulse only after an even count
				win_nxt[3] = zpar_r ? MK_ZERO : MK_BAL;
				win_nxt[0] = MK_VIOL;
				zpar_nxt = 1'b0;
			end else if (!ctrl_e1_r && zeros_in(win_nxt, 8)) begin
				// B8ZS: 000VB0VB, oldest first
				win_nxt[4] = MK_VIOL;
				win_nxt[3] = MK_BAL;
				win_nxt[1] = MK_VIOL;
				win_nxt[0] = MK_BAL;
			end
		end
	end

	// Window advances once per bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < WIN_LEN; i++) begin
				win_r[i] <= MK_ZERO;
			end
			zpar_r <= 1'b0;
		end else if (fifo_out_ready) begin
			win_r <= win_nxt;
			zpar_r <= zpar_nxt;
		end
	end

	// ----------------------------------------
	// All-ones timing from the master clock
	// ----------------------------------------
	// The stalled clock cannot pace the line, so bits come from a divider
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ais_cnt_r <= 4'h0;
		end else if (st_r != LS_ALL_ONES || ais_tick) begin
			ais_cnt_r <= 4'h0;
		end else begin
			ais_cnt_r <= ais_cnt_r + 4'h1;
		end
	end
	assign ais_tick = (ais_cnt_r == (ctrl_e1_r ? AIS_DIV_E1 : AIS_DIV_T1) - 4'h1);

	// ----------------------------------------
	// Line drivers
	// ----------------------------------------
	// Pulse rails, held for a full bit period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_out_tip <= 1'b0;
			line_out_ring <= 1'b0;
			last_pol_r <= 1'b0;
		end else if (st_r == LS_POWER_DOWN) begin
			line_out_tip <= 1'b0;
			line_out_ring <= 1'b0;
		end else if (st_r == LS_ALL_ONES) begin
			if (ais_tick) begin
				line_out_tip <= ~last_pol_r;
				line_out_ring <= last_pol_r;
				last_pol_r <= ~last_pol_r;
			end
		end else if (fifo_out_ready) begin
			if (!ctrl_single_r) begin
				line_out_tip <= fifo_out_valid & fifo_out_data[1] & ~fifo_out_data[0];
				line_out_ring <= fifo_out_valid & fifo_out_data[0] & ~fifo_out_data[1];
			end else begin
				case (win_r[WIN_LEN-1])
					MK_ONE, MK_BAL: begin
						line_out_tip <= ~last_pol_r;
						line_out_ring <= last_pol_r;
						last_pol_r <= ~last_pol_r;
					end
					MK_VIOL: begin
						line_out_tip <= last_pol_r;
						line_out_ring <= ~last_pol_r;
					end
					default: begin
						line_out_tip <= 1'b0;
						line_out_ring <= 1'b0;
					end
				endcase
			end
		end
	end

	// Output enables
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_out_tip_oe <= 1'b0;
			line_out_ring_oe <= 1'b0;
		end else begin
			line_out_tip_oe <= oe_s & ~ctrl_odis_r & (st_r != LS_POWER_DOWN);
			line_out_ring_oe <= oe_s & ~ctrl_odis_r & (st_r != LS_POWER_DOWN);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_hiz_when_disabled;
		(!oe_s || ctrl_odis_r) |=> !line_out_tip_oe && !line_out_ring_oe;
	endproperty
	a_hiz_when_disabled: assert property (p_hiz_when_disabled) else $error("line not floated");

	property p_all_ones_cause;
		$rose(st_r == LS_ALL_ONES) |-> $past(clk_s, 16) && $past(clk_s, 2);
	endproperty
	a_all_ones_cause: assert property (p_all_ones_cause) else $error("all ones without stall");

	property p_all_ones_exit;
		(st_r == LS_ALL_ONES) && toggled |=> (st_r == LS_NORMAL);
	endproperty
	a_all_ones_exit: assert property (p_all_ones_exit) else $error("all ones did not end");

	property p_pdown_float;
		$rose(st_r == LS_POWER_DOWN) |-> !$past(clk_s, 64) ##1 !line_out_tip_oe && !line_out_tip;
	endproperty
	a_pdown_float: assert property (p_pdown_float) else $error("power down not floated");

	property p_pdown_exit;
		(st_r == LS_POWER_DOWN) && toggled |=> (st_r == LS_NORMAL)
			##1 (line_out_tip_oe == $past(oe_s && !ctrl_odis_r));
	endproperty
	a_pdown_exit: assert property (p_pdown_exit) else $error("power up missed");

	property p_dual_space;
		!ctrl_single_r && fifo_out_ready && fifo_out_valid && (fifo_out_data == 2'h3)
			|=> !line_out_tip && !line_out_ring;
	endproperty
	a_dual_space: assert property (p_dual_space) else $error("11 pair not space");

	property p_ami_alternate;
		ctrl_single_r && fifo_out_ready && (win_r[WIN_LEN-1] == MK_ONE)
			|=> line_out_tip == !$past(last_pol_r) && line_out_ring == $past(last_pol_r);
	endproperty
	a_ami_alternate: assert property (p_ami_alternate) else $error("pulse not alternated");

	property p_sample_edge;
		// A falling-edge sample must land in the buffer; no pop shares that cycle
		clk_fall && !ctrl_inv_r && fifo_in_ready |=> fifo_out_valid;
	endproperty
	a_sample_edge: assert property (p_sample_edge) else $error("sample edge wrong");

	property p_coding_lock;
		wr_en && addr_is(paddr, ADDR_CTRL) && !pwdata[CTRL_SINGLE_RAIL] |=> $stable(ctrl_ami_r);
	endproperty
	a_coding_lock: assert property (p_coding_lock) else $error("coding changed in dual rail");

	property p_counters_clear;
		toggled |=> (hi_cnt_r == 5'h00) && (lo_cnt_r == 7'h00);
	endproperty
	a_counters_clear: assert property (p_counters_clear) else $error("stall count not cleared");

	c_all_ones: cover property ($rose(st_r == LS_ALL_ONES));
	c_power_down: cover property ($rose(st_r == LS_POWER_DOWN));
	c_fifo_full: cover property (!fifo_in_ready);
	c_hdb3_sub: cover property (fifo_out_ready && ctrl_e1_r && win_r[WIN_LEN-1] == MK_VIOL);
endmodule // tlf_tx_line_front_end

// file: tlf_framer_model.sv
// Purpose: Behavioural framer that drives the transmit clock and data pins.
// Assumes: Line rate and stall mode are chosen by the bench.
// Notes: Data changes on the rising clock edge; stalled data wanders on purpose.
module tlf_framer_model (
	// Control from the bench
	input wire logic e1_rate,
	input wire logic [1:0] run_mode,
	input wire logic pos_in,
	input wire logic neg_in,
	// Framer pins
	output logic tx_clock,
	output logic pos_out,
	output logic neg_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Mode 0 runs, 1 holds the clock high, 2 holds it low
	initial begin
		tx_clock = 1'b0;
		pos_out = 1'b0;
		neg_out = 1'b0;
		forever begin
			if (run_mode == 2'd0) begin
				#(e1_rate ? tlf_pkg::E1_BIT_NS / 2 : tlf_pkg::T1_BIT_NS / 2);
				tx_clock = 1'b1;
				pos_out = pos_in;
				neg_out = neg_in;
				#(e1_rate ? tlf_pkg::E1_BIT_NS / 2 : tlf_pkg::T1_BIT_NS / 2);
				tx_clock = 1'b0;
			end else begin
				// Data is not trusted while stalled, so it keeps changing
				tx_clock = run_mode[0];
				pos_out = ~pos_out;
				neg_out = ~neg_out;
				#50;
			end
		end
	end
endmodule // tlf_framer_model

// file: tb_top.sv
// Purpose: Self-checking bench for the transmit line front end.
// Assumes: Framer model drives the pins; APB master lives here.
// Notes: watch and the dual_line checks sample line outputs on the falling master-clock edge; the other checks sample after a rising edge.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tlf_pkg::*;

	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err, oe_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tip, ring, tip_oe, ring_oe, e1_rate, pos_in, neg_in, tx_clk, tx_pos, tx_neg, rnd_on;
	logic [1:0] run_mode, ex;
	logic [4:0] v, ctrl;
	logic [4:0] sr_cfg [4] = '{5'h03, 5'h01, 5'h05, 5'h03};
	int num_errors, tests_run, tips, rings, both;
	integer seed;

	// Free-running master clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	tlf_tx_line_front_end i_tlf_tx_line_front_end (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_channel_clock(tx_clk),
		.tx_positive_rail(tx_pos), .tx_negative_rail(tx_neg), .output_enable_pin(oe_pin),
		.line_out_tip(tip), .line_out_ring(ring), .line_out_tip_oe(tip_oe),
		.line_out_ring_oe(ring_oe));
	tlf_framer_model i_tlf_framer_model (.e1_rate(e1_rate), .run_mode(run_mode),
		.pos_in(pos_in), .neg_in(neg_in), .tx_clock(tx_clk), .pos_out(tx_pos), .neg_out(tx_neg));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) check("pready", 0, 1);
	endtask

	// Counts pulse starts on each rail and overlaps
	task automatic watch(input int n);
		logic pt, pr;
		tips = 0;
		rings = 0;
		both = 0;
		pt = tip;
		pr = ring;
		repeat (n) begin
			@(negedge clk);
			if (tip === 1'b1 && pt === 1'b0) tips++;
			if (ring === 1'b1 && pr === 1'b0) rings++;
			if (tip !== 1'b0 && ring !== 1'b0) both++;
			pt = tip;
			pr = ring;
		end
	endtask

	function automatic logic [1:0] dual_line(input logic p, input logic n);
		return (p ^ n) ? {p, n} : 2'b00;
	endfunction

	task results;
		if (num_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Random NRZ data for single-rail runs
	always @(posedge clk) begin
		if (rnd_on) pos_in <= 1'($random(seed));
	end

	// Hang guard, well past the expected run
	initial begin
		repeat (40000) @(posedge clk);
		check("watchdog", 0, 1);
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h203a5104;
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{e1_rate, run_mode, pos_in, neg_in, rnd_on} = '0;
		oe_pin = 1'b1;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values and an unmapped place
		apb(0, ADDR_CTRL, 0);
		check("ctrl_rst", rd, {27'h0, CTRL_RESET});
		check("ctrl_err", err, 0);
		apb(0, ADDR_STATUS, 0);
		check("status_rst", rd, 0);
		apb(1, 12'h008, 32'hffffffff);
		check("unmapped_wr_err", err, 1);
		apb(0, 12'h008, 0);
		check("unmapped_rd", rd, 0);
		check("unmapped_rd_err", err, 1);
		// Random control writes; coding choice only sticks in single rail
		ctrl = '0;
		repeat (6) begin
			v = 5'($random(seed));
			ctrl = {v[4:2], v[0] ? v[1] : ctrl[1], v[0]};
			apb(1, ADDR_CTRL, {27'h0, v});
			apb(0, ADDR_CTRL, 0);
			check("ctrl_rw", rd, {27'h0, ctrl});
		end
		apb(1, ADDR_CTRL, 1);
		// Dual-rail pairs at both rates and both sampling edges
		for (int k = 0; k < 12; k++) begin
			if (k % 6 == 0) apb(1, ADDR_CTRL, (k < 6) ? 32'h0 : 32'h0c);
			e1_rate <= (k >= 6);
			{pos_in, neg_in} <= (k % 6 < 4) ? 2'(k % 6) : 2'($random(seed));
			repeat (300) @(posedge clk);
			ex = dual_line(pos_in, neg_in);
			check("dual_oe", {tip_oe, ring_oe}, 2'b11);
			repeat (20) begin
				@(negedge clk);
				check("dual_line", {tip, ring}, ex);
			end
		end
		// Global enable pin, then the channel disable bit
		@(posedge clk);
		oe_pin <= 1'b0;
		repeat (6) @(posedge clk);
		check("oe_pin_low", {tip_oe, ring_oe}, 2'b00);
		oe_pin <= 1'b1;
		repeat (6) @(posedge clk);
		check("oe_pin_high", {tip_oe, ring_oe}, 2'b11);
		apb(1, ADDR_CTRL, 32'h1c);
		repeat (3) @(posedge clk);
		check("oe_disable", {tip_oe, ring_oe}, 2'b00);
		apb(1, ADDR_CTRL, 32'h0c);
		{pos_in, neg_in} <= 2'b10;
		// Transmit clock stalled high, then released
		run_mode <= 2'd1;
		repeat (8) @(posedge clk);
		apb(0, ADDR_STATUS, 0);
		check("ais_early", rd[STAT_ALL_ONES], 0);
		repeat (60) @(posedge clk);
		apb(0, ADDR_STATUS, 0);
		check("ais_on", rd[STAT_ALL_ONES], 1);
		watch(60);
		check("ais_pulses", {tips != 0, rings != 0, both == 0, tip_oe}, 4'hf);
		run_mode <= 2'd0;
		repeat (30) @(posedge clk);
		apb(0, ADDR_STATUS, 0);
		check("ais_off", rd[STAT_ALL_ONES], 0);
		repeat (300) @(posedge clk);
		check("ais_resume", {tip, ring}, 2'b10);
		// Transmit clock stalled low, then released
		run_mode <= 2'd2;
		repeat (40) @(posedge clk);
		check("pd_early", {tip_oe, ring_oe}, 2'b11);
		repeat (60) @(posedge clk);
		check("pd_float", {tip_oe, ring_oe, tip, ring}, 4'h0);
		apb(0, ADDR_STATUS, 0);
		check("pd_status", rd[STAT_PWR_DOWN], 1);
		run_mode <= 2'd0;
		repeat (30) @(posedge clk);
		check("pd_wake", {tip_oe, ring_oe}, 2'b11);
		apb(0, ADDR_STATUS, 0);
		check("pd_status_off", rd[STAT_PWR_DOWN], 0);
		repeat (300) @(posedge clk);
		check("pd_resume", {tip, ring}, 2'b10);
		// Single rail: AMI random, B8ZS zeros, HDB3 zeros, AMI zeros
		for (int c = 0; c < 4; c++) begin
			rnd_on <= (c == 0);
			e1_rate <= (c == 2);
			neg_in <= 1'b0;
			apb(1, ADDR_CTRL, {27'h0, sr_cfg[c]});
			if (c != 0) pos_in <= 1'b0;
			repeat (300) @(posedge clk);
			watch(400);
			check("sr_overlap", both, 0);
			if (c == 3) begin
				check("ami_zeros", tips + rings, 0);
			end else begin
				check("sr_pulses", {tips != 0, rings != 0}, 2'b11);
			end
			if (c == 0) check("ami_balance", (tips - rings + 1) <= 2, 1);
		end
		// Each low stall strands one sample, as the wake edge pops nothing
		for (int i = 0; i < 20; i++) begin
			run_mode <= 2'd2;
			repeat (90) @(posedge clk);
			apb(0, ADDR_STATUS, 0);
			if (rd[STAT_FIFO_FULL] === 1'b1) break;
			run_mode <= 2'd0;
			repeat (20) @(posedge clk);
		end
		check("fifo_full", rd[STAT_FIFO_FULL], 1);
		check("ovf_hold", rd[STAT_OVERFLOW], 0);
		// Wake with a full buffer: the first new sample is dropped
		run_mode <= 2'd0;
		repeat (40) @(posedge clk);
		apb(0, ADDR_STATUS, 0);
		check("ovf_set", rd[STAT_OVERFLOW], 1);
		apb(1, ADDR_STATUS, 32'h0000_0008);
		apb(0, ADDR_STATUS, 0);
		check("ovf_clear", rd[STAT_OVERFLOW], 0);
		results();
	end
endmodule // tb_top
